// ---- design/fadc_encoder.sv ----
`timescale 1ns/10ps
`include "fadc_defines.svh"
module fadc_encoder
    import fadc_pkg::*;
(
    fadc_enc_if.enc bus
);
    logic [`FADC_NUM_CMP-1:0] onehot;
    logic [`FADC_CODE_W-1:0] bin;

    // Stage one: mark the top of the thermometer column
    always_comb begin
        for (int i = 0; i < `FADC_NUM_CMP; i++) begin
            if (i == `FADC_NUM_CMP - 1) begin
                onehot[i] = bus.thermo[i];
            end else begin
                onehot[i] = bus.thermo[i] & ~bus.thermo[i+1];
            end
        end
    end

    // Stage two: OR the marked position into binary weights
    always_comb begin
        bin = '0;
        for (int i = 0; i < `FADC_NUM_CMP; i++) begin
            logic [`FADC_CODE_W-1:0] w;
            w = `FADC_CODE_W'(i + 1);
            if (onehot[i]) begin
                bin = bin | w;
            end
        end
    end

    // Stage three: clamp, full column gives 255 with no overflow flag
    always_comb begin
        if (bus.thermo[`FADC_NUM_CMP-1]) begin
            bus.code = `FADC_CODE_MAX;
        end else begin
            bus.code = bin;
        end
    end
endmodule // fadc_encoder

// ---- design/fadc_top.sv ----
`timescale 1ns/10ps
`include "fadc_defines.svh"
module fadc_top
    import fadc_pkg::*;
#(
    parameter int ANA_W = `FADC_ANA_W,
    parameter int OUT_DELAY_CYC = `FADC_OUT_DELAY_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Analog input, sampled digitally
    input wire logic [ANA_W-1:0] i_analog_in,
    // Strobes from the outside party
    input wire logic i_sample_strobe,
    input wire logic i_output_strobe,
    // Sample output
    output logic [`FADC_CODE_W-1:0] o_code_out,
    output logic o_code_valid
);
    localparam int DCW = $clog2(OUT_DELAY_CYC + 1);
    localparam int SHIFT = ANA_W - `FADC_CODE_W;
    localparam logic [ANA_W-1:0] TH_FIRST = {8'h01, {SHIFT{1'b0}}};
    localparam logic [ANA_W-1:0] TH_LAST = {8'hff, {SHIFT{1'b0}}};

    typedef struct packed {
        logic [1:0] samp_sync;
        logic [1:0] outs_sync;
        logic samp_prev;
        logic outs_prev;
        logic [ANA_W-1:0] ana_s0;
        logic [ANA_W-1:0] ana_s1;
        logic [`FADC_NUM_CMP-1:0] track;
        logic [`FADC_NUM_CMP-1:0] stage1;
        logic [`FADC_CODE_W-1:0] stage2;
        fadc_out_phase_t phase;
        logic [DCW-1:0] dly_cnt;
        logic [`FADC_CODE_W-1:0] code_out;
        logic valid;
    } fadc_state_t;

    fadc_state_t r_reg;
    fadc_state_t r_next;
    logic [`FADC_NUM_CMP-1:0] cmp_thermo;
    logic samp_high;
    logic samp_rise;
    logic outs_high;
    logic outs_rise;

    fadc_enc_if u_bus();

    assign u_bus.thermo = r_reg.stage1;

    fadc_encoder u_enc (
        .bus(u_bus)
    );

    assign samp_high = r_reg.samp_sync[1];
    assign samp_rise = r_reg.samp_sync[1] & ~r_reg.samp_prev;
    assign outs_high = r_reg.outs_sync[1];
    assign outs_rise = r_reg.outs_sync[1] & ~r_reg.outs_prev;

    // Comparator field, thresholds one LSB apart over the span
    always_comb begin
        for (int k = 1; k <= `FADC_NUM_CMP; k++) begin
            logic [ANA_W-1:0] th;
            th = {8'(k), {SHIFT{1'b0}}};
            cmp_thermo[k-1] = (r_reg.ana_s1 >= th);
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.samp_sync = {r_reg.samp_sync[0], i_sample_strobe};
        r_next.outs_sync = {r_reg.outs_sync[0], i_output_strobe};
        r_next.samp_prev = r_reg.samp_sync[1];
        r_next.outs_prev = r_reg.outs_sync[1];
        r_next.ana_s0 = i_analog_in;
        r_next.ana_s1 = r_reg.ana_s0;

        // Comparators follow the input only in the low phase
        if (!samp_high) begin
            r_next.track = cmp_thermo;
        end
        // Master latch loads on the rise and holds through the high phase
        if (samp_rise) begin
            r_next.stage1 = r_reg.track;
        end
        // Slave latch open while low, frozen from the rise onward
        if (!outs_high) begin
            r_next.stage2 = u_bus.code;
        end

        case (r_reg.phase)
            FADC_OUT_TRANSP: begin
                // Open latch lets first-stage changes through
                r_next.code_out = r_reg.stage2;
                r_next.valid = 1'b0;
                r_next.dly_cnt = '0;
                if (outs_rise) begin
                    r_next.phase = FADC_OUT_DELAY;
                end
            end
            FADC_OUT_DELAY: begin
                if (!outs_high) begin
                    r_next.phase = FADC_OUT_TRANSP;
                end else if (r_reg.dly_cnt == DCW'(OUT_DELAY_CYC - 1)) begin
                    r_next.code_out = r_reg.stage2;
                    r_next.valid = 1'b1;
                    r_next.phase = FADC_OUT_HOLD;
                end else begin
                    r_next.dly_cnt = r_reg.dly_cnt + DCW'(1);
                end
            end
            FADC_OUT_HOLD: begin
                // Window closes when the output strobe drops
                if (!outs_high) begin
                    r_next.valid = 1'b0;
                    r_next.phase = FADC_OUT_TRANSP;
                end
            end
            default: begin
                r_next.phase = FADC_OUT_TRANSP;
                r_next.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_code_out = r_reg.code_out;
    assign o_code_valid = r_reg.valid;

    a_cmp_first_bit: assert property (@(posedge i_clk) disable iff (i_reset)
        !samp_high |=> r_reg.track[0] == ($past(r_reg.ana_s1) >= TH_FIRST)
    ) else $error("lowest comparator disagrees with its threshold");

    a_cmp_last_bit: assert property (@(posedge i_clk) disable iff (i_reset)
        !samp_high |=> r_reg.track[254] == ($past(r_reg.ana_s1) >= TH_LAST)
    ) else $error("highest comparator disagrees with its threshold");

    a_enc_code_count: assert property (@(posedge i_clk) disable iff (i_reset)
        u_bus.code == 8'($countones(r_reg.stage1))
    ) else $error("encoded code differs from comparator count");

    a_code_lsb_step: assert property (@(posedge i_clk) disable iff (i_reset)
        ($countones(r_reg.stage1) == $countones($past(r_reg.stage1)) + 1)
            |-> u_bus.code == $past(u_bus.code) + 8'h01
    ) else $error("one more comparator did not step code by one");

    a_code_saturate: assert property (@(posedge i_clk) disable iff (i_reset)
        (&r_reg.stage1) |-> u_bus.code == `FADC_CODE_MAX
    ) else $error("full column does not give 255");

    a_track_follow: assert property (@(posedge i_clk) disable iff (i_reset)
        !samp_high |=> r_reg.track == $past(cmp_thermo)
    ) else $error("comparators not tracking in low phase");

    a_master_capture: assert property (@(posedge i_clk) disable iff (i_reset)
        samp_rise |=> r_reg.stage1 == $past(r_reg.track) ##1 (!samp_high || $stable(r_reg.stage1))
    ) else $error("first latch did not capture or hold");

    a_slave_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        outs_high |=> $stable(r_reg.stage2)
    ) else $error("second latch moved while output strobe high");

    a_out_delay: assert property (@(posedge i_clk) disable iff (i_reset)
        (outs_rise && r_reg.phase == FADC_OUT_TRANSP) ##1 outs_high
            |=> o_code_valid && o_code_out == r_reg.stage2
    ) else $error("stored value not on outputs after delay");

    a_transp_pass: assert property (@(posedge i_clk) disable iff (i_reset)
        r_reg.phase == FADC_OUT_TRANSP |=> o_code_out == $past(r_reg.stage2)
    ) else $error("outputs not following open second latch");

    a_window_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        o_code_valid && outs_high |=> $stable(o_code_out)
    ) else $error("output changed inside valid window");
endmodule // fadc_top

// ---- shared/fadc_defines.svh ----
// How it works
// - Each of 255 comparators says whether the analog input lies at or above its own evenly spaced threshold.
// - A three-stage encoder turns the thermometer pattern into an unsigned 8-bit code on the eight output lines.
// - The code steps by one for every rise of one LSB, which is the full reference span over 256.
// - There is no overflow flag, and above the range the code sits at 255.
// - While the sample strobe is low the comparators follow the input and hold nothing.
// - The first latch catches the comparison on the sample strobe rise and keeps it until the next rise of that strobe.
// - The second latch is transparent while the output strobe is low and stores on its rise.
// - The stored value reaches the outputs a fixed delay after the output strobe rises.
// - While the output strobe is low the outputs may move, since first-stage changes pass the open second latch.
`ifndef FADC_DEFINES_SVH
`define FADC_DEFINES_SVH

`define FADC_NUM_CMP 255
`define FADC_CODE_W 8
`define FADC_CODE_MAX 8'hff
`define FADC_LSB_DIV 256
`define FADC_ANA_W 10
`define FADC_CLK_PERIOD_NS 10
`define FADC_OUT_DELAY_NS 7
`define FADC_OUT_DELAY_CYC \
    ((`FADC_OUT_DELAY_NS + `FADC_CLK_PERIOD_NS - 1) / `FADC_CLK_PERIOD_NS)

`endif

// ---- shared/fadc_enc_if.sv ----
`timescale 1ns/10ps
`include "fadc_defines.svh"
interface fadc_enc_if;
    logic [`FADC_NUM_CMP-1:0] thermo;
    logic [`FADC_CODE_W-1:0] code;
    modport enc (input thermo, output code);
    modport user (output thermo, input code);
endinterface // fadc_enc_if

// ---- shared/fadc_pkg.sv ----
package fadc_pkg;
    typedef enum logic [1:0] {
        FADC_OUT_TRANSP,
        FADC_OUT_DELAY,
        FADC_OUT_HOLD
    } fadc_out_phase_t;
endpackage

// ---- testbench/fadc_strobe_model.sv ----
`timescale 1ns/10ps
`include "fadc_defines.svh"
module fadc_strobe_model (
    // Clock
    input wire logic i_clk,
    // Sample from the converter
    input wire logic [`FADC_CODE_W-1:0] i_code_out,
    input wire logic i_code_valid,
    // Strobes to the converter
    output logic o_sample_strobe,
    output logic o_output_strobe
);
    initial begin
        o_sample_strobe = 1'b0;
        o_output_strobe = 1'b0;
    end

    // Open output latch, let comparators track, then capture
    task automatic sample_edge(input int track);
        // Sample strobe is already low here, from reset or the last window
        o_output_strobe = 1'b0;
        repeat (track) @(negedge i_clk);
        o_sample_strobe = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask

    // Freeze output latch while sample strobe is still high
    task automatic output_edge(output logic [`FADC_CODE_W-1:0] seen, output bit ok);
        int n;
        o_output_strobe = 1'b1;
        n = 0;
        while (i_code_valid !== 1'b1 && n < 12) begin
            @(negedge i_clk);
            n++;
        end
        ok = (i_code_valid === 1'b1);
        seen = i_code_out;
        repeat (2) @(negedge i_clk);
        o_sample_strobe = 1'b0;
    endtask
endmodule // fadc_strobe_model

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`include "fadc_defines.svh"
module testbench
    import fadc_pkg::*;
;
    typedef struct {
        logic [9:0] ana;
        logic [7:0] code;
    } fadc_row_t;

    logic clk;
    logic reset;
    logic [9:0] analog_in;
    logic sample_strobe;
    logic output_strobe;
    logic [7:0] code_out;
    logic code_valid;
    logic [7:0] seen;
    bit ok;
    int errors = 0;
    int comparisons = 0;
    fadc_row_t rows[9] = '{'{10'h000, 8'h00}, '{10'h003, 8'h00}, '{10'h004, 8'h01},
        '{10'h005, 8'h01}, '{10'h1ff, 8'h7f}, '{10'h200, 8'h80}, '{10'h3fb, 8'hfe},
        '{10'h3fc, 8'hff}, '{10'h3ff, 8'hff}};

    fadc_top #(.ANA_W(10), .OUT_DELAY_CYC(1)) uut (
        .i_clk(clk),
        .i_reset(reset),
        .i_analog_in(analog_in),
        .i_sample_strobe(sample_strobe),
        .i_output_strobe(output_strobe),
        .o_code_out(code_out),
        .o_code_valid(code_valid)
    );

    fadc_strobe_model partner (
        .i_clk(clk),
        .i_code_out(code_out),
        .i_code_valid(code_valid),
        .o_sample_strobe(sample_strobe),
        .o_output_strobe(output_strobe)
    );

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Input moves to later after the sample edge
    task automatic convert(input logic [9:0] ana, input logic [9:0] later);
        analog_in = ana;
        partner.sample_edge(6);
        check("valid outside window", {7'h00, code_valid}, 8'h00);
        analog_in = later;
        partner.output_edge(seen, ok);
        check("valid in window", {7'h00, ok}, 8'h01);
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        analog_in = 10'h000;
        repeat (8) @(negedge clk);
        check("code in reset", code_out, 8'h00);
        check("valid in reset", {7'h00, code_valid}, 8'h00);
        reset = 1'b0;
        $display("Test reset done");
        foreach (rows[i]) begin
            convert(rows[i].ana, rows[i].ana);
            check("code", seen, rows[i].code);
        end
        $display("Test table done");
        // Tracked value is new after saturation; later input change ignored
        convert(10'h0c8, 10'h3ff);
        check("held code", seen, 8'h32);
        convert(10'h3ff, 10'h000);
        check("held top code", seen, 8'hff);
        $display("Test capture hold done");
        // Reset in the middle of an open window
        reset = 1'b1;
        repeat (2) @(negedge clk);
        check("code after mid reset", code_out, 8'h00);
        check("valid after mid reset", {7'h00, code_valid}, 8'h00);
        reset = 1'b0;
        convert(10'h155, 10'h155);
        check("code after recovery", seen, 8'h55);
        $display("Test mid reset done");
        conclude;
    end

    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        $display("Watchdog expired");
        conclude;
    end
endmodule // testbench
